// ### hdl/uart_tx_rx_core.sv
// Purpose: Full-duplex serial transceiver with AXI4-Lite control and status registers
// Assumes: Single 125 MHz clock; rx_line is asynchronous to it
// Notes: No FIFOs, no interrupts, no break characters
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module uart_tx_rx_core
	import uart_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Transmit byte stream
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// Receive byte stream
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	// Error status of the last frame
	output logic parity_err,
	output logic frame_err,
	// Serial line
	output logic tx_line,
	input wire logic rx_line
);
	// Register bus state
	logic aw_got_q; // Write address held
	logic w_got_q; // Write data held
	logic [AXI_AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic wr_go; // Both halves of a write present
	logic [31:0] wr_val; // Register value after byte-lane merge
	// Software-visible registers
	logic [CTRL_W-1:0] ctrl_q; // Enables, parity, frame mode
	logic [DIV_W-1:0] div_q; // Bit-rate divisor
	logic [STAT_W-1:0] stat_w; // Live status view
	// Decoded configuration
	logic tx_en;
	logic rx_en;
	logic [1:0] par_mode;
	logic par_en;
	logic two_stop;
	// Transmitter
	frame_st_t tx_st_q;
	logic [7:0] tx_sh_q; // Outgoing shifter
	logic [2:0] tx_bit_q; // Data bit index
	logic tx_par_q; // Parity of the byte in flight
	logic tx_line_q; // Registered line level
	logic tx_take; // Byte handshake this cycle
	// Receiver
	frame_st_t rx_st_q;
	logic rx_s; // Synchronised line
	logic [2:0] rx_ph_q; // Oversample phase in bit
	logic [2:0] rx_bit_q; // Data bit index
	logic [7:0] rx_sh_q; // Incoming shifter
	logic rx_par_q; // Sampled parity bit
	logic rx_stop_bad_q; // First of two stop bits was low
	logic [7:0] rx_data_q;
	logic rx_valid_q;
	logic perr_q;
	logic ferr_q;
	logic rx_smp; // Mid-bit sample strobe
	logic rx_end; // End-of-bit strobe
	logic rx_done; // Last stop bit sampled
	logic rx_bad; // Any stop bit low
	logic perr_d; // Parity check result

	uart_tick_if tk ();

	// Line synchroniser
	uart_sync2 u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(rx_line),
		.dout(rx_s)
	);

	// Bit-rate generator
	uart_baud u_baud (
		.aclk(aclk),
		.aresetn(aresetn),
		.tk(tk.gen)
	);

	// Word address of a byte address
	function automatic logic [AXI_AW-1:0] word_of(input logic [AXI_AW-1:0] a);
		return {a[AXI_AW-1:2], 2'h0};
	endfunction

	// Mapped register test, used by both channels
	function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
		return (word_of(a) == OFS_CTRL) || (word_of(a) == OFS_DIV) || (word_of(a) == OFS_STAT);
	endfunction

	// Register read mux; unused bits read zero
	function automatic logic [31:0] reg_read(input logic [AXI_AW-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (word_of(a))
			OFS_CTRL: v[CTRL_W-1:0] = ctrl_q;
			OFS_DIV: v[DIV_W-1:0] = div_q;
			OFS_STAT: v[STAT_W-1:0] = stat_w;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Merge new bytes into the old word by strobe
	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				v[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return v;
	endfunction

	// Configuration fields
	assign tx_en = ctrl_q[CTRL_TX_EN];
	assign rx_en = ctrl_q[CTRL_RX_EN];
	assign par_mode = ctrl_q[CTRL_PAR_LSB +: 2];
	// low bit zero means no parity
	assign par_en = par_mode[0];
	assign two_stop = (ctrl_q[CTRL_FRAME] == FRAME_TWO_STOP);
	assign tk.div = div_q;

	// Status view
	always_comb begin
		stat_w = '0;
		stat_w[STAT_TX_RDY] = tx_ready;
		stat_w[STAT_RX_VLD] = rx_valid_q;
		stat_w[STAT_PERR] = perr_q;
		stat_w[STAT_FERR] = ferr_q;
		stat_w[STAT_TX_BUSY] = (tx_st_q != ST_IDLE);
	end

	// Address and data are taken in either order; nothing new until the response leaves
	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready = !w_got_q && !bvalid_q;
	assign wr_go = aw_got_q && w_got_q && !bvalid_q;
	// Process form, so the merge also follows register changes seen inside the read function
	always_comb begin
		wr_val = strb_merge(reg_read(awaddr_q), wdata_q, wstrb_q);
	end

	// Write address holder
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			awaddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_got_q <= 1'b0;
		end
	end

	// Write data holder
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_go) begin
			w_got_q <= 1'b0;
		end
	end

	// Write response; unmapped words answer with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= reg_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Writable registers; status writes are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			div_q <= DIV_RST;
		end else if (wr_go) begin
			if (word_of(awaddr_q) == OFS_CTRL) begin
				ctrl_q <= wr_val[CTRL_W-1:0];
			end
			if (word_of(awaddr_q) == OFS_DIV) begin
				div_q <= wr_val[DIV_W-1:0];
			end
		end
	end

	// Read channel, one read in flight
	assign s_axi_arready = !rvalid_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_q <= reg_read(s_axi_araddr);
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	assign tx_ready = tx_en && (tx_st_q == ST_IDLE);
	assign tx_take = tx_valid && tx_ready;
	assign tk.tx_run = (tx_st_q != ST_IDLE);
	assign tx_line = tx_line_q;

	// Transmit sequencer; the start bit begins on the handshake, each later bit change waits for the one-times tick
	always_ff @(posedge aclk) begin
		if (!aresetn || !tx_en) begin
			tx_st_q <= ST_IDLE;
			tx_line_q <= 1'b1;
			tx_sh_q <= 8'h00;
			tx_bit_q <= 3'h0;
			tx_par_q <= 1'b0;
		end else begin
			case (tx_st_q)
				ST_IDLE: begin
					if (tx_take) begin
						tx_st_q <= ST_START;
						tx_line_q <= 1'b0;
						tx_sh_q <= tx_data;
						tx_par_q <= par_bit(tx_data, par_mode);
					end
				end
				ST_START: begin
					if (tk.tick_tx) begin
						tx_st_q <= ST_DATA;
						tx_line_q <= tx_sh_q[0];
						tx_bit_q <= 3'h0;
					end
				end
				ST_DATA: begin
					if (tk.tick_tx) begin
						if (tx_bit_q == BIT_LAST) begin
							tx_st_q <= par_en ? ST_PAR : ST_STOP1;
							tx_line_q <= par_en ? tx_par_q : 1'b1;
						end else begin
							tx_bit_q <= 3'(tx_bit_q + 3'h1);
							tx_sh_q <= {1'b0, tx_sh_q[7:1]};
							tx_line_q <= tx_sh_q[1];
						end
					end
				end
				ST_PAR: begin
					if (tk.tick_tx) begin
						tx_st_q <= ST_STOP1;
						tx_line_q <= 1'b1;
					end
				end
				ST_STOP1: begin
					if (tk.tick_tx) begin
						tx_st_q <= two_stop ? ST_STOP2 : ST_IDLE;
					end
				end
				ST_STOP2: begin
					if (tk.tick_tx) begin
						tx_st_q <= ST_IDLE;
					end
				end
				default: begin
					tx_st_q <= ST_IDLE;
					tx_line_q <= 1'b1;
				end
			endcase
		end
	end

	assign rx_smp = tk.tick_rx && (rx_ph_q == PH_SAMPLE);
	assign rx_end = tk.tick_rx && (rx_ph_q == PH_LAST);
	assign tk.rx_run = (rx_st_q != ST_IDLE);
	// Frame closes at mid-stop, leaving half a bit to catch the next start
	assign rx_done = rx_smp && (((rx_st_q == ST_STOP1) && !two_stop) || (rx_st_q == ST_STOP2));
	// any low stop is a fault
	assign rx_bad = !rx_s || ((rx_st_q == ST_STOP2) && rx_stop_bad_q);
	assign perr_d = par_en && (rx_par_q != par_bit(rx_sh_q, par_mode));

	// Receive sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn || !rx_en) begin
			rx_st_q <= ST_IDLE;
			rx_ph_q <= 3'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_par_q <= 1'b0;
			rx_stop_bad_q <= 1'b0;
		end else begin
			if (rx_st_q == ST_IDLE) begin
				rx_ph_q <= 3'h0;
			end else if (tk.tick_rx) begin
				rx_ph_q <= 3'(rx_ph_q + 3'h1);
			end
			case (rx_st_q)
				ST_IDLE: begin
					if (!rx_s) begin
						rx_st_q <= ST_START;
					end
				end
				ST_START: begin
					// A start that is high at mid-bit was a glitch
					if (rx_smp && rx_s) begin
						rx_st_q <= ST_IDLE;
					end else if (rx_end) begin
						rx_st_q <= ST_DATA;
						rx_bit_q <= 3'h0;
					end
				end
				ST_DATA: begin
					if (rx_smp) begin
						rx_sh_q <= {rx_s, rx_sh_q[7:1]};
					end
					if (rx_end) begin
						if (rx_bit_q == BIT_LAST) begin
							rx_st_q <= par_en ? ST_PAR : ST_STOP1;
						end else begin
							rx_bit_q <= 3'(rx_bit_q + 3'h1);
						end
					end
				end
				ST_PAR: begin
					if (rx_smp) begin
						rx_par_q <= rx_s;
					end
					if (rx_end) begin
						rx_st_q <= ST_STOP1;
					end
				end
				ST_STOP1: begin
					if (rx_smp && !two_stop) begin
						rx_st_q <= ST_IDLE;
					end else if (rx_smp) begin
						rx_stop_bad_q <= !rx_s;
					end else if (rx_end && two_stop) begin
						rx_st_q <= ST_STOP2;
					end
				end
				ST_STOP2: begin
					if (rx_smp) begin
						rx_st_q <= ST_IDLE;
					end
				end
				default: begin
					rx_st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Received byte hand-off; a new byte overwrites an unread one
	// stop fault withholds valid
	always_ff @(posedge aclk) begin
		if (!aresetn || !rx_en) begin
			rx_valid_q <= 1'b0;
			rx_data_q <= 8'h00;
		end else if (rx_done && !rx_bad) begin
			rx_valid_q <= 1'b1;
			rx_data_q <= rx_sh_q;
		end else if (rx_valid_q && rx_ready) begin
			rx_valid_q <= 1'b0;
		end
	end
	assign rx_valid = rx_valid_q;
	assign rx_data = rx_data_q;

	// flags change only at frame end, and clear on reset or when receive is disabled
	always_ff @(posedge aclk) begin
		if (!aresetn || !rx_en) begin
			perr_q <= 1'b0;
			ferr_q <= 1'b0;
		end else if (rx_done) begin
			perr_q <= perr_d;
			ferr_q <= rx_bad;
		end
	end
	assign parity_err = perr_q;
	assign frame_err = ferr_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_tx_take;
		tx_valid && tx_ready;
	endsequence

	property p_tx_take;
		s_tx_take |=> (tx_st_q == ST_START) && !tx_line && (tx_sh_q == $past(tx_data));
	endproperty
	a_tx_take: assert property (p_tx_take) else $error("byte not captured on handshake");

	property p_tx_busy;
		s_tx_take |=> !tx_ready [*8];
	endproperty
	a_tx_busy: assert property (p_tx_busy) else $error("ready during a frame");

	property p_tx_abort;
		$fell(tx_en) |=> tx_line && (tx_st_q == ST_IDLE);
	endproperty
	a_tx_abort: assert property (p_tx_abort) else $error("disable did not idle the line");

	property p_rx_drop;
		rx_done && rx_bad |=> frame_err && !$rose(rx_valid) && $stable(rx_data);
	endproperty
	a_rx_drop: assert property (p_rx_drop) else $error("framing fault byte was offered");

	property p_rx_keep;
		rx_done && !rx_bad |=> rx_valid && (rx_data == $past(rx_sh_q)) && (parity_err == $past(perr_d));
	endproperty
	a_rx_keep: assert property (p_rx_keep) else $error("good frame not offered");

	sequence s_quiet;
		(rx_en && !rx_done) ##1 rx_en;
	endsequence

	property p_err_hold;
		s_quiet |-> $stable(parity_err) && $stable(frame_err);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag moved mid-frame");

	property p_rx_mid;
		(rx_st_q == ST_DATA) && $changed(rx_sh_q) |-> $past(rx_smp);
	endproperty
	a_rx_mid: assert property (p_rx_mid) else $error("data sampled off mid-bit");
endmodule
`default_nettype wire

// ### hdl/uart_pkg.sv
// Purpose: Constants, register map, frame states and parity helper for the transceiver
// Assumes: One 125 MHz core clock and a synchronous active-low reset
// Notes: Shared by the core, the bit-rate generator and the bench
// Contract
// - Flag parity mismatch of last byte
// - Keep parity-faulted byte readable
// - Flag framing fault on low stop bit
// - Drop byte on framing fault
// - Single clock, synchronous active-low reset
// - Oversample tick every divisor plus one
// - One-times and eight-times ticks, same divisor
// - Receive enable starts start-bit watch
// - Enables may drop at any cycle
// - Byte taken when valid and ready
// - Ready only when enabled and idle
// - Parity mode: none, odd, even
// - Frame mode: one or two stops
// - Data bits least significant first
// - Byte leaves when valid and ready
package uart_pkg;
	// Core clock and reset figures
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned RST_HOLD_CYC = 8; // Least reset hold the controller must give
	// Bit-rate generator
	localparam int unsigned DIV_W = 16;
	localparam logic [15:0] DIV_RST = 16'h0001; // Fastest legal rate
	localparam logic [2:0] PH_SAMPLE = 3'h3; // Fourth oversample tick is mid-bit
	localparam logic [2:0] PH_LAST = 3'h7; // Eighth tick closes a bit
	localparam logic [2:0] BIT_LAST = 3'h7; // Eight data bits per frame
	// Register bus
	localparam int unsigned AXI_AW = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DIV = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Control register fields
	localparam int unsigned CTRL_W = 5;
	localparam int unsigned CTRL_TX_EN = 0;
	localparam int unsigned CTRL_RX_EN = 1;
	localparam int unsigned CTRL_PAR_LSB = 2;
	localparam int unsigned CTRL_FRAME = 4;
	localparam logic [4:0] CTRL_RST = 5'h00;
	// Status register fields
	localparam int unsigned STAT_W = 5;
	localparam int unsigned STAT_TX_RDY = 0;
	localparam int unsigned STAT_RX_VLD = 1;
	localparam int unsigned STAT_PERR = 2;
	localparam int unsigned STAT_FERR = 3;
	localparam int unsigned STAT_TX_BUSY = 4;
	// Line format codes
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	localparam logic FRAME_TWO_STOP = 1'h1;

	// Frame position, shared by both directions
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_PAR = 3'b011,
		ST_STOP1 = 3'b100,
		ST_STOP2 = 3'b101
	} frame_st_t;

	// Parity bit for a byte; mode PAR_EVEN picks even, any other code odd
	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] mode);
		return (mode == PAR_EVEN) ? ^d : ~^d;
	endfunction
endpackage

// ### hdl/uart_tick_if.sv
// Purpose: Bundle between the core and its bit-rate generator
// Assumes: Both ends on the core clock
// Notes: Ticks are single-cycle strobes
`timescale 1ns/10ps
`default_nettype none
interface uart_tick_if;
	logic [15:0] div; // Divisor, one tick per div+1 cycles
	logic tx_run; // Transmit frame under way
	logic rx_run; // Receive frame under way
	logic tick_tx; // One-times bit strobe
	logic tick_rx; // Eight-times sample strobe
	modport gen (input div, input tx_run, input rx_run, output tick_tx, output tick_rx);
	modport core (output div, output tx_run, output rx_run, input tick_tx, input tick_rx);
endinterface
`default_nettype wire

// ### hdl/uart_sync2.sv
// Purpose: Two-stage synchroniser for the serial input
// Assumes: Input is asynchronous to aclk
// Notes: Resets to the idle-high line level
`timescale 1ns/10ps
`default_nettype none
module uart_sync2 (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Line in, synchronised line out
	input wire logic din,
	output logic dout
);
	logic meta_q; // Only the second stage reads this
	logic sync_q; // Safe copy of the line

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end
	assign dout = sync_q;
endmodule
`default_nettype wire

// ### hdl/uart_baud.sv
// Purpose: Bit-rate generator with separate transmit and receive prescalers
// Assumes: Divisor stays stable while a direction runs
// Notes: Each prescaler restarts with its frame, so bit edges line up with the frame start
`timescale 1ns/10ps
`default_nettype none
module uart_baud
	import uart_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Run requests in, ticks out
	uart_tick_if.gen tk
);
	logic [DIV_W-1:0] tx_cnt_q; // Transmit prescaler
	logic [2:0] tx_ph_q; // Sub-ticks toward a whole bit
	logic [DIV_W-1:0] rx_cnt_q; // Receive prescaler
	logic [DIV_W-1:0] gap_q; // Cycles since last receive tick, for checking
	logic tx_sub; // Transmit-side eighth of a bit

	assign tx_sub = (tx_cnt_q == tk.div);
	assign tk.tick_tx = tx_sub && (tx_ph_q == PH_LAST);
	assign tk.tick_rx = (rx_cnt_q == tk.div);

	always_ff @(posedge aclk) begin
		if (!aresetn || !tk.tx_run) begin
			tx_cnt_q <= '0;
			tx_ph_q <= '0;
		end else if (tx_sub) begin
			tx_cnt_q <= '0;
			tx_ph_q <= 3'(tx_ph_q + 3'h1);
		end else begin
			tx_cnt_q <= DIV_W'(tx_cnt_q + 1'b1);
		end
	end

	// Receive prescaler, held clear while no frame is seen
	always_ff @(posedge aclk) begin
		if (!aresetn || !tk.rx_run || tk.tick_rx) begin
			rx_cnt_q <= '0;
		end else begin
			rx_cnt_q <= DIV_W'(rx_cnt_q + 1'b1);
		end
	end

	// Interval model seen only by the checks; it wraps on its own count, not on the tick
	always_ff @(posedge aclk) begin
		if (!aresetn || !tk.rx_run || (gap_q == tk.div)) begin
			gap_q <= '0;
		end else begin
			gap_q <= DIV_W'(gap_q + 1'b1);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_rx_gap;
		tk.rx_run |-> (tk.tick_rx == (gap_q == tk.div));
	endproperty
	a_rx_gap: assert property (p_rx_gap) else $error("oversample tick spacing wrong");

	property p_tx_slow;
		$rose(tk.tx_run) |-> !tk.tick_tx [*8];
	endproperty
	a_tx_slow: assert property (p_tx_slow) else $error("bit tick too early after frame start");
endmodule
`default_nettype wire

// ### testbench/uart_remote.sv
// Purpose: Remote serial device on the far side of the lines
// Assumes: One bit lasts BIT core cycles
// Notes: Drives rx_line with frames, decodes tx_line
`timescale 1ns/10ps
`default_nettype none
module uart_remote #(
	parameter int BIT = 16
) (
	// Clock
	input wire logic aclk,
	// Line format
	input wire logic [1:0] par_mode,
	input wire logic two_stop,
	// Serial lines
	input wire logic tx_line,
	output logic rx_line,
	// Decoded byte, got pulses one cycle
	output logic got,
	output logic got_ok,
	output logic [7:0] got_data
);
	logic ok; // Parity and stops good
	initial begin
		rx_line = 1'b1;
		got = 1'b0;
		got_ok = 1'b0;
		got_data = 8'h00;
	end
	task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
		logic q[$];
		q = {1'b0};
		for (int i = 0; i < 8; i++) q.push_back(d[i]);
		if (par_mode[0]) q.push_back((par_mode[1] ? ^d : ~^d) ^ bad_par);
		q.push_back(~bad_stop);
		if (two_stop) q.push_back(1'b1);
		foreach (q[i]) begin
			rx_line <= q[i];
			repeat (BIT) @(posedge aclk);
		end
		rx_line <= 1'b1;
	endtask
	always begin
		@(negedge tx_line);
		repeat (BIT / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge aclk);
			got_data[i] = tx_line;
		end
		ok = 1'b1;
		if (par_mode[0]) begin
			repeat (BIT) @(posedge aclk);
			ok = tx_line == (par_mode[1] ? ^got_data : ~^got_data);
		end
		for (int i = 0; i <= int'(two_stop); i++) begin
			repeat (BIT) @(posedge aclk);
			ok = ok & tx_line;
		end
		got <= 1'b1;
		got_ok <= ok;
		@(posedge aclk);
		got <= 1'b0;
	end
endmodule
`default_nettype wire

// ### testbench/uart_tx_rx_core_bench.sv
// Purpose: Self-checking bench for the transceiver
// Assumes: Divisor one, so a bit is 16 cycles
// Notes: Expected results queue up, a watcher compares
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("Error %0t: got %h want %h", $time, a, b); end end
module uart_tx_rx_core_bench;
	import uart_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, tx_data = 0, rx_data, got_data, d;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb = 4'hf; // Full words only
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic tx_valid = 0, rx_ready = 1, tx_ready, rx_valid, parity_err, frame_err, tx_line, rx_line;
	logic [1:0] s_axi_bresp, s_axi_rresp, wr_r, rd_r, pm = 0;
	logic two = 0, got, got_ok;
	logic [9:0] rxq[$], txq[$], exp_v; // Expected results
	int errors = 0, compares = 0, seed = 32'h28ee;
	always #4 aclk = ~aclk;
	uart_tx_rx_core i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_data,
		.tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .parity_err, .frame_err, .tx_line, .rx_line);
	uart_remote i_rem (.aclk, .par_mode(pm), .two_stop(two), .tx_line, .rx_line, .got, .got_ok, .got_data);
	// Register write; ready sampled mid-cycle, when it is settled
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 99; i++) begin
			@(negedge aclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			wr_r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			// Bready stays high, so a following call never drives it twice in one step
			if (tb) break;
		end
	endtask
	// Register read
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 99; i++) begin
			@(negedge aclk);
			ta = s_axi_arready;
			tr = s_axi_rvalid;
			rd_d = s_axi_rdata;
			rd_r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			// Rready stays high for the same reason
			if (tr) break;
		end
	endtask
	// Hand one byte over; w waits for the far side to decode it
	task automatic xfer(input logic [7:0] v, input logic w);
		logic t;
		if (w) txq.push_back({2'b01, v});
		tx_data <= v;
		tx_valid <= 1'b1;
		// byte and valid held until taken
		for (int i = 0; i < 999; i++) begin
			@(negedge aclk);
			t = tx_ready;
			@(posedge aclk);
			if (t) begin
				tx_valid <= 1'b0;
				break;
			end
		end
		@(negedge aclk);
		`CHK(tx_ready, 1'b0)
		@(posedge aclk);
		for (int i = 0; w && txq.size() > 0 && i < 999; i++) @(posedge aclk);
	endtask
	task complete_run;
		$display("Compares %0d, errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Result watcher; an unexpected byte finds the queue empty
	always @(posedge aclk) begin
		if (rx_valid && rx_ready) begin
			`CHK(rxq.size() > 0, 1'b1)
			if (rxq.size() > 0) begin
				exp_v = rxq.pop_front();
				`CHK({frame_err, parity_err, rx_data}, exp_v)
			end
		end
		if (got && txq.size() > 0) begin
			exp_v = txq.pop_front();
			`CHK({1'b0, got_ok, got_data}, exp_v)
		end
	end
	// Watchdog
	initial begin
		repeat (40000) @(posedge aclk);
		errors++;
		$display("Error %0t: timeout", $time);
		complete_run;
	end
	initial begin
		repeat (RST_HOLD_CYC) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFS_DIV);
		`CHK({rd_r, rd_d}, {RESP_OKAY, 32'h0000_0001})
		rd(8'h0c);
		`CHK(rd_r, RESP_SLVERR)
		wr(8'h0c, 32'h0000_0003);
		`CHK(wr_r, RESP_SLVERR)
		`CHK({tx_line, tx_ready}, 2'b10)
		$display("Test reset done");
		for (int m = 0; m < 6; m++) begin
			// Mode 3 uses the other no-parity code
			pm = (m % 3 == 0) ? ((m == 3) ? 2'b10 : 2'b00) : (m % 3 == 1) ? PAR_ODD : PAR_EVEN;
			two = m >= 3;
			wr(OFS_CTRL, {27'h0, two, pm, 2'b00});
			wr(OFS_CTRL, {27'h0, two, pm, 2'b11});
			rd(OFS_STAT);
			`CHK({wr_r, rd_r, rd_d}, {RESP_OKAY, RESP_OKAY, 32'h0000_0001})
			xfer(8'($random(seed)), 1'b1);
			xfer(8'($random(seed)), 1'b1);
			d = 8'($random(seed));
			rxq.push_back({2'b00, d});
			i_rem.send(d, 1'b0, 1'b0);
			if (pm[0]) begin
				d = 8'($random(seed));
				rxq.push_back({2'b01, d});
				i_rem.send(d, 1'b1, 1'b0);
			end
			i_rem.send(8'($random(seed)), 1'b0, 1'b1);
			@(negedge aclk);
			`CHK({frame_err, rx_valid}, 2'b10)
			`CHK({rxq.size() == 0, txq.size() == 0}, 2'b11)
			@(posedge aclk);
			$display("Test format %0d done", m);
		end
		xfer(8'h00, 1'b0);
		repeat (40) @(posedge aclk);
		wr(OFS_CTRL, 32'h0000_0000);
		@(negedge aclk);
		`CHK({tx_line, tx_ready}, 2'b10)
		repeat (300) @(posedge aclk);
		$display("Test abort done");
		complete_run;
	end
endmodule
`default_nettype wire
